/* File: mhu_cfg.svh */
`ifndef MHU_CFG_SVH
`define MHU_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// register indices; byte address is four times the index
`define MHU_IDX_DATA 4'h0
`define MHU_IDX_DIVH 4'h1
`define MHU_IDX_LCTL 4'h3
`define MHU_IDX_MCTL 4'h4
`define MHU_IDX_RELAY 4'h5
`define MHU_IDX_LSTATE 4'h6
`define MHU_IDX_SCRATCH 4'h7
`define MHU_IDX_ISTAT 4'h8
`define MHU_IDX_IMASK 4'h9

////////////////////////////////////////////////////////////////////////////
// field positions
`define MHU_DAB_BIT 7
`define MHU_DTR_BIT 0
`define MHU_RTS_BIT 1
`define MHU_AUX1_BIT 2
`define MHU_AUX2_BIT 3
`define MHU_LOOP_BIT 4
`define MHU_LN_CTS 0
`define MHU_LN_DSR 1
`define MHU_LN_RI 2
`define MHU_LN_DCD 3
`define MHU_EV_MSI 0
`define MHU_EV_RX 1
`define MHU_EV_OVR 2

////////////////////////////////////////////////////////////////////////////
// reset values
`define MHU_DIV_RST 16'h0180
`define MHU_BYTE_RST 8'h00

`endif

/* File: mhu_pkg.sv */
package mhu_pkg;

   // modem line levels, high means asserted
   typedef struct packed {
      logic dcd;
      logic ri;
      logic dsr;
      logic cts;
   } mhu_lines_s;

   // byte handed over by the receive engine
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } mhu_rx_s;

   // state of the pin synchroniser
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] stable;
   } mhu_sync_s;

   // state of the register block
   typedef struct packed {
      logic act;
      logic wr;
      logic [3:0] idx;
      logic rdy;
      logic [7:0] rdata;
      logic [7:0] div_lo;
      logic [7:0] div_hi;
      logic [7:0] lctl;
      logic [4:0] mctl;
      logic [2:0] relay;
      logic [7:0] scratch;
      logic [7:0] receive_buffer;
      logic rx_full;
      logic [3:0] snap;
      logic [3:0] flags;
      logic [2:0] istat;
      logic [2:0] imask;
      logic irq;
      logic [3:0] led;
      logic [7:0] tx_byte;
      logic tx_load;
   } mhu_state_s;

endpackage : mhu_pkg

/* File: mhu_line_sync.sv */
`include "mhu_cfg.svh"

module mhu_line_sync (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // pins in, filtered levels out
   input wire mhu_pkg::mhu_lines_s lines_in,
   output mhu_pkg::mhu_lines_s lines_out
);
   import mhu_pkg::*;

   mhu_sync_s s;
   mhu_sync_s next_s;
   logic [3:0] upd;

   ////////////////////////////////////////////////////////////////////////
   // a level counts only once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_bit
         assign upd[g] = (s.s2[g] == s.s3[g]) ? s.s3[g] : s.stable[g];
      end
   endgenerate

   // the first stage is read by the second stage only
   always_comb begin
      next_s = s;
      next_s.s1 = lines_in;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.stable = upd;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign lines_out = s.stable;

endmodule : mhu_line_sync

/* File: mhu_regs.sv */
// Implementation choice: the AHB-Lite register port.
`include "mhu_cfg.svh"

module mhu_regs (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // modem line pins
   input wire mhu_pkg::mhu_lines_s line_pins,
   // receive and transmit engine
   input wire mhu_pkg::mhu_rx_s rx_in,
   output logic [7:0] tx_byte,
   output logic tx_load,
   output logic [15:0] divisor,
   // indicators, relays, interrupt
   output logic [3:0] led,
   output logic [2:0] relay,
   output logic irq
);
   import mhu_pkg::*;

   mhu_state_s s;
   mhu_state_s next_s;
   mhu_lines_s pins_sync;
   logic [3:0] cur;
   logic [3:0] chg;
   logic acc;
   logic rd_acc;
   logic rd_msr;
   logic rd_rbr;
   logic dab;
   logic [3:0] aidx;
   logic [7:0] wbyte;
   // reset divisor split into its two bytes
   localparam logic [15:0] div_rst = `MHU_DIV_RST;

   ////////////////////////////////////////////////////////////////////////
   // pin synchroniser
   mhu_line_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .lines_in(line_pins),
      .lines_out(pins_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // current line states, pins or loopback mirror
   assign cur[`MHU_LN_DCD] = s.mctl[`MHU_LOOP_BIT] ?
      s.mctl[`MHU_AUX2_BIT] : pins_sync.dcd;
   assign cur[`MHU_LN_RI] = s.mctl[`MHU_LOOP_BIT] ?
      s.mctl[`MHU_AUX1_BIT] : pins_sync.ri;
   assign cur[`MHU_LN_DSR] = s.mctl[`MHU_LOOP_BIT] ?
      s.mctl[`MHU_DTR_BIT] : pins_sync.dsr;
   assign cur[`MHU_LN_CTS] = s.mctl[`MHU_LOOP_BIT] ?
      s.mctl[`MHU_RTS_BIT] : pins_sync.cts;

   // differences against the snapshot taken at the last status read; ring flags only a fall from the snapshot
   assign chg[`MHU_LN_DCD] = cur[`MHU_LN_DCD] ^ s.snap[`MHU_LN_DCD];
   assign chg[`MHU_LN_RI] = s.snap[`MHU_LN_RI] & ~cur[`MHU_LN_RI];
   assign chg[`MHU_LN_DSR] = cur[`MHU_LN_DSR] ^ s.snap[`MHU_LN_DSR];
   assign chg[`MHU_LN_CTS] = cur[`MHU_LN_CTS] ^ s.snap[`MHU_LN_CTS];

   // address phase decode; only the index bits take part
   assign acc = hsel & hready & htrans[1];
   assign aidx = haddr[5:2];
   assign rd_acc = acc & ~hwrite;
   assign dab = s.lctl[`MHU_DAB_BIT];
   assign rd_msr = rd_acc & (aidx == `MHU_IDX_LSTATE);
   assign rd_rbr = rd_acc & (aidx == `MHU_IDX_DATA) & ~dab;
   assign wbyte = hwdata[7:0];

   ////////////////////////////////////////////////////////////////////////
   // next state: writes first, then events, then the read mux
   always_comb begin
      next_s = s;
      next_s.rdy = 1'b1;
      next_s.tx_load = 1'b0;
      next_s.act = acc;
      next_s.wr = hwrite;
      next_s.idx = aidx;
      // data phase write; hwdata is valid only now
      if (s.act && s.wr) begin
         unique case (s.idx)
            `MHU_IDX_DATA: begin
               if (dab) begin
                  next_s.div_lo = wbyte;
               end else begin
                  next_s.tx_byte = wbyte;
                  next_s.tx_load = 1'b1;
               end
            end
            `MHU_IDX_DIVH: begin
               if (dab) begin
                  next_s.div_hi = wbyte;
               end
            end
            `MHU_IDX_LCTL: next_s.lctl = wbyte;
            `MHU_IDX_MCTL: next_s.mctl = wbyte[4:0];
            `MHU_IDX_RELAY: next_s.relay = wbyte[2:0];
            `MHU_IDX_SCRATCH: next_s.scratch = wbyte;
            `MHU_IDX_ISTAT: next_s.istat = s.istat & ~wbyte[2:0];
            `MHU_IDX_IMASK: next_s.imask = wbyte[2:0];
            default: begin
               // unmapped or read-only: write ignored
            end
         endcase
      end
      // change flags; a status read clears them after reporting
      next_s.flags = s.flags | chg;
      if (rd_msr) begin
         next_s.flags = 4'h0;
         next_s.snap = cur;
      end
      // receive byte; a new byte in the read cycle keeps the buffer full
      if (rd_rbr) begin
         next_s.rx_full = 1'b0;
      end
      if (rx_in.valid) begin
         next_s.receive_buffer = rx_in.data;
         next_s.rx_full = 1'b1;
      end
      // sticky events win over the write-one clear
      if ((|s.flags) || (|chg)) begin
         next_s.istat[`MHU_EV_MSI] = 1'b1;
      end
      if (rx_in.valid) begin
         next_s.istat[`MHU_EV_RX] = 1'b1;
      end
      if (rx_in.valid && s.rx_full && !rd_rbr) begin
         next_s.istat[`MHU_EV_OVR] = 1'b1;
      end
      next_s.irq = |(next_s.istat & next_s.imask);
      next_s.led = cur;
      // read mux sees this cycle's write so back-to-back reads are fresh
      next_s.rdata = 8'h00;
      if (rd_acc) begin
         unique case (aidx)
            `MHU_IDX_DATA: next_s.rdata = dab ? next_s.div_lo : s.receive_buffer;
            `MHU_IDX_DIVH: next_s.rdata = dab ? next_s.div_hi : 8'h00;
            `MHU_IDX_LCTL: next_s.rdata = next_s.lctl;
            `MHU_IDX_MCTL: next_s.rdata = {3'h0, next_s.mctl};
            `MHU_IDX_RELAY: next_s.rdata = {5'h0, next_s.relay};
            `MHU_IDX_LSTATE: next_s.rdata = {cur, s.flags | chg};
            `MHU_IDX_SCRATCH: next_s.rdata = next_s.scratch;
            `MHU_IDX_ISTAT: next_s.rdata = {5'h0, next_s.istat};
            `MHU_IDX_IMASK: next_s.rdata = {5'h0, next_s.imask};
            default: next_s.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; reset clears the change flags and snapshot
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.div_lo <= div_rst[7:0];
         s.div_hi <= div_rst[15:8];
         s.scratch <= `MHU_BYTE_RST;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, each straight from the state register except hresp, tied low
   assign hrdata = {24'h000000, s.rdata};
   assign hreadyout = s.rdy;
   assign hresp = 1'b0;
   assign tx_byte = s.tx_byte;
   assign tx_load = s.tx_load;
   assign divisor = {s.div_hi, s.div_lo};
   assign led = s.led;
   assign relay = s.relay;
   assign irq = s.irq;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_msr_layout: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_msr |=> (hrdata[7:4] == $past(cur)) && (hrdata[31:8] == 24'h000000))
      else $error("status read shows wrong line states");

   a_change_set: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (cur[`MHU_LN_CTS] != s.snap[`MHU_LN_CTS]) && !rd_msr
      |=> s.flags[`MHU_LN_CTS])
      else $error("clear-to-send change not flagged");

   a_flags_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_msr |=> (s.flags == 4'h0) && (s.snap == $past(cur)))
      else $error("status read did not clear change flags");

   a_msi_raise: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (|s.flags) |=> s.istat[`MHU_EV_MSI] && (!s.imask[`MHU_EV_MSI] || irq))
      else $error("change flag did not raise modem interrupt");

   a_loop_ring: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s.mctl[`MHU_LOOP_BIT] |=> led[`MHU_LN_RI] == $past(s.mctl[`MHU_AUX1_BIT]))
      else $error("ring does not mirror first aux bit in loopback");

   a_loop_ready: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s.mctl[`MHU_LOOP_BIT] |=> led[`MHU_LN_DSR] == $past(s.mctl[`MHU_DTR_BIT]))
      else $error("set-ready does not mirror terminal-ready in loopback");

   a_loop_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s.mctl[`MHU_LOOP_BIT] |=> led[`MHU_LN_CTS] == $past(s.mctl[`MHU_RTS_BIT]))
      else $error("clear-to-send does not mirror request bit in loopback");

   a_loop_carrier: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s.mctl[`MHU_LOOP_BIT] |=> led[`MHU_LN_DCD] == $past(s.mctl[`MHU_AUX2_BIT]))
      else $error("carrier does not mirror second aux bit in loopback");

   a_ring_rise: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !s.flags[`MHU_LN_RI] && !s.snap[`MHU_LN_RI] |=> !s.flags[`MHU_LN_RI])
      else $error("ring flag set without a falling edge");

   a_ring_fall: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s.snap[`MHU_LN_RI] && !cur[`MHU_LN_RI] && !rd_msr |=> s.flags[`MHU_LN_RI])
      else $error("ring falling edge not flagged");

   a_div_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s.act && s.wr && (s.idx == `MHU_IDX_DIVH) && dab
      |=> divisor[15:8] == $past(hwdata[7:0]))
      else $error("divisor high byte not written");

   a_tx_load: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s.act && s.wr && (s.idx == `MHU_IDX_DATA) && !dab
      |=> tx_load && (tx_byte == $past(hwdata[7:0]))
      ##1 (tx_load == $past(s.act && s.wr && (s.idx == `MHU_IDX_DATA) && !dab)))
      else $error("transmit byte not loaded for one cycle");

   a_ready_change: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (cur[`MHU_LN_DSR] != s.snap[`MHU_LN_DSR]) && !rd_msr
      |=> s.flags[`MHU_LN_DSR])
      else $error("set-ready change not flagged");

   a_carrier_change: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (cur[`MHU_LN_DCD] != s.snap[`MHU_LN_DCD]) && !rd_msr
      |=> s.flags[`MHU_LN_DCD])
      else $error("carrier change not flagged");

   a_flags_sticky: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !rd_msr
      |=> (s.flags & $past(s.flags)) == $past(s.flags))
      else $error("change flag dropped without a status read");

   a_flags_quiet: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !rd_msr && (chg == 4'h0)
      |=> s.flags == $past(s.flags))
      else $error("change flag set without a line change");

   a_pin_ring: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !s.mctl[`MHU_LOOP_BIT]
      |=> led[`MHU_LN_RI] == $past(pins_sync.ri))
      else $error("ring state does not follow its pin");

   a_pin_ready: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !s.mctl[`MHU_LOOP_BIT]
      |=> led[`MHU_LN_DSR] == $past(pins_sync.dsr))
      else $error("set-ready state does not follow its pin");

   a_pin_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !s.mctl[`MHU_LOOP_BIT]
      |=> led[`MHU_LN_CTS] == $past(pins_sync.cts))
      else $error("clear-to-send state does not follow its pin");

   a_pin_carrier: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !s.mctl[`MHU_LOOP_BIT]
      |=> led[`MHU_LN_DCD] == $past(pins_sync.dcd))
      else $error("carrier state does not follow its pin");

   a_scratch_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s.act && s.wr && (s.idx == `MHU_IDX_SCRATCH)
      |=> s.scratch == $past(hwdata[7:0]))
      else $error("scratch byte not written");

   a_relay_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s.act && s.wr && (s.idx == `MHU_IDX_RELAY)
      |=> relay == $past(hwdata[2:0]))
      else $error("relay outputs not written");

   a_div_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s.act && s.wr && (s.idx == `MHU_IDX_DATA) && dab
      |=> (divisor[7:0] == $past(hwdata[7:0])) && !tx_load)
      else $error("divisor low byte not written");

   a_div_guard: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s.act && s.wr && (s.idx == `MHU_IDX_DIVH) && !dab
      |=> $stable(divisor))
      else $error("divisor changed with divisor access off");

   a_rbr_read: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_rbr
      |=> hrdata[7:0] == $past(s.receive_buffer))
      else $error("received byte not returned on read");

endmodule : mhu_regs

/* File: mhu_host_model.sv */
module mhu_host_model (
   // bus clock and slave answer
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // request signals toward the slave
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // bus idle until the first transfer
   initial begin
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////
   // one single word transfer; index scaled to a byte address
   // waits are open, only the bench watchdog ends a stuck slave
   task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wdat,
                       output logic [7:0] rdat);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {26'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, wdat};
      do @(posedge hclk); while (hready !== 1'b1);
      rdat = hrdata[7:0];
   endtask : xfer

endmodule : mhu_host_model

/* File: modem_host_uart_registers_test.sv */
`include "mhu_cfg.svh"

module modem_host_uart_registers_test import mhu_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, tx_load, irq;
   logic [1:0] htrans;
   logic [2:0] hsize, relay;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] tx_byte;
   logic [15:0] divisor;
   logic [3:0] led;
   mhu_lines_s line_pins = 4'h0;
   mhu_rx_s rx_in = 9'h0;
   int num_errors = 0;
   int check_count = 0;
   logic [15:0] tbl [4] = '{16'h0180, 16'h00C0, 16'h0060, 16'h0030};

   // 200 MHz clock
   always #2.5 hclk = ~hclk;

   mhu_host_model i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   mhu_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .line_pins(line_pins),
      .rx_in(rx_in), .tx_byte(tx_byte), .tx_load(tx_load), .divisor(divisor), .led(led),
      .relay(relay), .irq(irq));

   ////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("errors %0d, checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [7:0] ignored;
      i_host.xfer(1'b1, idx, d, ignored);
   endtask : wr

   task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      i_host.xfer(1'b0, idx, 8'h00, r);
      check({8'h00, r}, {8'h00, exp});
   endtask : rd_chk

   // let filtered pins and registered outputs settle
   task automatic settle();
      repeat (8) @(posedge hclk);
      #1;
   endtask : settle

   ////////////////////////////////////////////////////////////////////////
   // every baud table entry through both divisor bytes
   task automatic t_divisor();
      wr(`MHU_IDX_LCTL, 8'h80);
      for (int i = 0; i < 4; i++) begin
         wr(`MHU_IDX_DATA, tbl[i][7:0]);
         wr(`MHU_IDX_DIVH, tbl[i][15:8]);
         rd_chk(`MHU_IDX_DATA, tbl[i][7:0]);
         rd_chk(`MHU_IDX_DIVH, tbl[i][15:8]);
         check(divisor, tbl[i]);
      end
      wr(`MHU_IDX_LCTL, 8'h00);
   endtask : t_divisor

   // scratch holds any value; unmapped index reads zero
   task automatic t_scratch();
      rd_chk(`MHU_IDX_SCRATCH, 8'h00);
      wr(`MHU_IDX_SCRATCH, 8'hA5);
      rd_chk(`MHU_IDX_SCRATCH, 8'hA5);
      wr(`MHU_IDX_SCRATCH, 8'h5A);
      rd_chk(`MHU_IDX_SCRATCH, 8'h5A);
      rd_chk(4'hF, 8'h00);
   endtask : t_scratch

   // transmit write pulses, received byte read back and its event cleared
   task automatic t_data();
      wr(`MHU_IDX_DATA, 8'h3C);
      #1;
      check({15'h0, tx_load}, 16'h0001);
      check({8'h00, tx_byte}, 16'h003C);
      @(posedge hclk);
      rx_in <= {1'b1, 8'h96};
      @(posedge hclk);
      rx_in <= {1'b0, 8'h96};
      rd_chk(`MHU_IDX_DATA, 8'h96);
      rd_chk(`MHU_IDX_ISTAT, 8'h02);
      wr(`MHU_IDX_ISTAT, 8'h02);
      rd_chk(`MHU_IDX_ISTAT, 8'h00);
      // two bytes with no read between: second overwrites, overrun flagged
      @(posedge hclk);
      rx_in <= {1'b1, 8'h11};
      @(posedge hclk);
      rx_in <= {1'b1, 8'h22};
      @(posedge hclk);
      rx_in <= {1'b0, 8'h22};
      rd_chk(`MHU_IDX_ISTAT, 8'h06);
      rd_chk(`MHU_IDX_DATA, 8'h22);
      wr(`MHU_IDX_ISTAT, 8'h06);
      rd_chk(`MHU_IDX_ISTAT, 8'h00);
   endtask : t_data

   // rising pins, then a ring fall; ring rise alone sets no flag
   task automatic t_status();
      wr(`MHU_IDX_IMASK, 8'h01);
      @(posedge hclk);
      line_pins <= 4'hF;
      settle();
      check({15'h0, irq}, 16'h0001);
      rd_chk(`MHU_IDX_LSTATE, 8'hFB);
      rd_chk(`MHU_IDX_LSTATE, 8'hF0);
      check({12'h000, led}, 16'h000F);
      @(posedge hclk);
      line_pins <= 4'hB;
      settle();
      rd_chk(`MHU_IDX_LSTATE, 8'hB4);
      wr(`MHU_IDX_ISTAT, 8'h01);
      repeat (3) @(posedge hclk);
      #1;
      check({15'h0, irq}, 16'h0000);
   endtask : t_status

   // loopback maps control bits onto the four states
   task automatic t_loop();
      wr(`MHU_IDX_MCTL, 8'h15);
      settle();
      rd_chk(`MHU_IDX_LSTATE, 8'h69);
      check({12'h000, led}, 16'h0006);
      wr(`MHU_IDX_MCTL, 8'h1A);
      settle();
      rd_chk(`MHU_IDX_LSTATE, 8'h9F);
      check({12'h000, led}, 16'h0009);
      rd_chk(`MHU_IDX_MCTL, 8'h1A);
   endtask : t_loop

   task automatic t_relay();
      wr(`MHU_IDX_RELAY, 8'h05);
      rd_chk(`MHU_IDX_RELAY, 8'h05);
      check({13'h0, relay}, 16'h0005);
   endtask : t_relay

   ////////////////////////////////////////////////////////////////////////
   // main sequence, reset values checked while reset is held
   initial begin
      repeat (7) @(posedge hclk);
      #1;
      check(divisor, 16'h0180);
      check({12'h000, led}, 16'h0000);
      check({12'h000, irq, relay}, 16'h0000);
      @(posedge hclk);
      hresetn <= 1'b1;
      t_divisor();
      t_scratch();
      t_data();
      t_status();
      t_loop();
      t_relay();
      print_verdict();
   end

   // watchdog, far beyond the two hundred or so cycles the tests need
   initial begin
      repeat (20000) @(posedge hclk);
      num_errors++;
      print_verdict();
   end

endmodule : modem_host_uart_registers_test
